//--- src/pps_pkg.sv
// constants and types for the pll status and lock pin select block
package pps_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W             = 10;
  localparam int          DATA_W             = 8;
  localparam logic [9:0]  OFS_CNT_SYNC_DELAY = 10'h019;
  localparam logic [9:0]  OFS_LOCK_PIN_CTRL  = 10'h01A;
  localparam logic [7:0]  RST_CNT_SYNC_DELAY = 8'h00;
  localparam logic [7:0]  RST_LOCK_PIN_CTRL  = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED     = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SYNC_MODE_HI  = 7;
  localparam int SYNC_MODE_LO  = 6;
  localparam int REF_DLY_HI    = 5;
  localparam int REF_DLY_LO    = 3;
  localparam int FB_DLY_HI     = 2;
  localparam int FB_DLY_LO     = 0;
  localparam int STAT_DIV_BIT  = 7;
  localparam int LOCK_SEL_HI   = 5;
  localparam int LOCK_SEL_LO   = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SYNC_IGNORE_LO = 2'h0,
    SYNC_ASYNC_RST = 2'h1,
    SYNC_SYNC_RST  = 2'h2,
    SYNC_IGNORE    = 2'h3
  } pps_sync_mode_e;

  localparam logic [5:0] LSEL_LEVEL_OUTPUT   = 6'h00;
  localparam logic [5:0] LSEL_DYN_PCHAN      = 6'h01;
  localparam logic [5:0] LSEL_DYN_NCHAN      = 6'h02;
  localparam logic [5:0] LSEL_HIGH_IMPEDANCE = 6'h03;
  localparam logic [5:0] LSEL_CURRENT_SOURCE = 6'h04;

  localparam logic [1:0] STAT_DIV_LAST = 2'h3;

  // ---------------------------------------------------------------
  // register access request
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } pps_reg_req_s;

endpackage

//--- src/pps_top.sv
// pll counter sync response, path delays, status divider, lock pin select
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
module pps_top
  import pps_pkg::*;
(
  input  wire logic         MCLK_I,
  input  wire logic         RST_N_I,
  input  wire pps_reg_req_s REG_REQ_I,
  output logic [7:0]        REG_RDATA_O,
  output logic              REG_RVALID_O,
  input  wire logic         SYNC_PIN_N_I,
  output logic              CNT_RST_ASYNC_O,
  output logic              CNT_RST_SYNC_O,
  output logic [2:0]        REF_PATH_DELAY_O,
  output logic [2:0]        FB_PATH_DELAY_O,
  input  wire logic         STATUS_SIG_I,
  output logic              STATUS_PIN_O,
  input  wire logic         DIGITAL_LOCK_FLAG_I,
  input  wire logic         ANALOG_LOCK_I,
  output logic              LOCK_PIN_O,
  output logic              LOCK_PIN_OE_O,
  output logic              LOCK_CUR_SRC_EN_O
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]     cnt_sync_q;
  logic [7:0]     lock_ctrl_q;
  logic [2:0]     sync_pipe_q;
  logic           sync_act_q;
  logic           stat_prev_q;
  logic [1:0]     stat_cnt_q;
  logic           stat_pin_q;
  logic           lock_pin_q;
  logic           lock_oe_q;
  logic           cur_en_q;
  logic           lock_pin_d;
  logic           lock_oe_d;
  logic           cur_en_d;
  pps_sync_mode_e sync_mode;
  logic [5:0]     lock_sel;

  assign sync_mode = pps_sync_mode_e'(cnt_sync_q[SYNC_MODE_HI:SYNC_MODE_LO]);
  assign lock_sel  = lock_ctrl_q[LOCK_SEL_HI:LOCK_SEL_LO];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // shared by the write and read paths so both agree on the map
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // ---------------------------------------------------------------
  // register write
  // ---------------------------------------------------------------
  // writes to unmapped addresses are dropped without any side effect
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt_sync_q  <= RST_CNT_SYNC_DELAY;
      lock_ctrl_q <= RST_LOCK_PIN_CTRL;
    end else if (REG_REQ_I.wr) begin
      if (hit(REG_REQ_I.addr, OFS_CNT_SYNC_DELAY)) begin
        cnt_sync_q <= REG_REQ_I.wdata;
      end else if (hit(REG_REQ_I.addr, OFS_LOCK_PIN_CTRL)) begin
        lock_ctrl_q <= REG_REQ_I.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // read answers one cycle later; unmapped addresses read as zero
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O  <= RDATA_UNMAPPED;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_REQ_I.rd;
      if (!REG_REQ_I.rd) begin
        REG_RDATA_O <= REG_RDATA_O;
      end else if (hit(REG_REQ_I.addr, OFS_CNT_SYNC_DELAY)) begin
        REG_RDATA_O <= cnt_sync_q;
      end else if (hit(REG_REQ_I.addr, OFS_LOCK_PIN_CTRL)) begin
        REG_RDATA_O <= lock_ctrl_q;
      end else begin
        REG_RDATA_O <= RDATA_UNMAPPED;
      end
    end
  end

  // ---------------------------------------------------------------
  // path delay selects
  // ---------------------------------------------------------------
  assign REF_PATH_DELAY_O = cnt_sync_q[REF_DLY_HI:REF_DLY_LO];
  assign FB_PATH_DELAY_O  = cnt_sync_q[FB_DLY_HI:FB_DLY_LO];

  // ---------------------------------------------------------------
  // sync pin response
  // ---------------------------------------------------------------
  // the asynchronous reset bypasses the clock so it acts even when
  // the register clock is idle; it is the only unregistered output
  assign CNT_RST_ASYNC_O = (sync_mode == SYNC_ASYNC_RST)
                           && !SYNC_PIN_N_I;

  // reset to the idle high level so no false sync follows reset
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync_pipe_q <= 3'h7;
      sync_act_q  <= 1'b0;
    end else begin
      sync_pipe_q <= {sync_pipe_q[1:0], SYNC_PIN_N_I};
      if (sync_pipe_q[2] == sync_pipe_q[1]) begin
        sync_act_q <= !sync_pipe_q[1];
      end
    end
  end

  // modes 00 and 11 leave the counters alone
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CNT_RST_SYNC_O <= 1'b0;
    end else begin
      CNT_RST_SYNC_O <= (sync_mode == SYNC_SYNC_RST)
                        && sync_act_q;
    end
  end

  // ---------------------------------------------------------------
  // status pin divider
  // ---------------------------------------------------------------
  // limitation: input pulses shorter than one register clock are missed
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_prev_q <= 1'b0;
      stat_cnt_q  <= 2'h0;
      stat_pin_q  <= 1'b0;
    end else begin
      stat_prev_q <= STATUS_SIG_I;
      if (!lock_ctrl_q[STAT_DIV_BIT]) begin
        stat_cnt_q <= 2'h0;
        stat_pin_q <= STATUS_SIG_I;
      end else if (STATUS_SIG_I && !stat_prev_q) begin
        // toggle every second rising edge: output period is four inputs
        stat_cnt_q <= stat_cnt_q + 2'h1;
        if (stat_cnt_q[0]) begin
          stat_pin_q <= !stat_pin_q;
        end
      end
    end
  end
  assign STATUS_PIN_O = stat_pin_q;

  // ---------------------------------------------------------------
  // lock pin select
  // ---------------------------------------------------------------
  // registered so the pin cannot glitch while the selector is rewritten
  always_comb begin
    lock_pin_d = 1'b0;
    lock_oe_d  = 1'b1;
    cur_en_d   = 1'b0;
    case (lock_sel)
      LSEL_LEVEL_OUTPUT: begin
        lock_pin_d = DIGITAL_LOCK_FLAG_I;
      end
      LSEL_DYN_PCHAN: begin
        lock_pin_d = 1'b1;
        lock_oe_d  = ANALOG_LOCK_I;
      end
      LSEL_DYN_NCHAN: begin
        lock_pin_d = 1'b0;
        lock_oe_d  = ANALOG_LOCK_I;
      end
      LSEL_HIGH_IMPEDANCE: begin
        lock_oe_d = 1'b0;
      end
      LSEL_CURRENT_SOURCE: begin
        // the pin is fed by the analog current source, not the driver
        lock_oe_d = 1'b0;
        cur_en_d  = DIGITAL_LOCK_FLAG_I;
      end
      default: begin
        lock_pin_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lock_pin_q <= 1'b0;
      lock_oe_q  <= 1'b1;
      cur_en_q   <= 1'b0;
    end else begin
      lock_pin_q <= lock_pin_d;
      lock_oe_q  <= lock_oe_d;
      cur_en_q   <= cur_en_d;
    end
  end
  // the pad combines level and enable; open drain uses the enable only
  assign LOCK_PIN_O        = lock_pin_q;
  assign LOCK_PIN_OE_O     = lock_oe_q;
  assign LOCK_CUR_SRC_EN_O = cur_en_q;

endmodule

//--- test/pps_top_properties.sv
// concurrent checks on the ports of the pll status and lock pin block
`timescale 1ns/1ns
module pps_props
  import pps_pkg::*;
(
  input wire logic         MCLK_I,
  input wire logic         RST_N_I,
  input wire pps_reg_req_s REG_REQ_I,
  input wire logic         REG_RVALID_O,
  input wire logic         SYNC_PIN_N_I,
  input wire logic         CNT_RST_ASYNC_O,
  input wire logic         CNT_RST_SYNC_O,
  input wire logic         DIGITAL_LOCK_FLAG_I,
  input wire logic         ANALOG_LOCK_I,
  input wire logic         LOCK_PIN_O,
  input wire logic         LOCK_PIN_OE_O,
  input wire logic         LOCK_CUR_SRC_EN_O
);
  logic [7:0] cs_q;
  logic [7:0] lk_q;
  // shadow copies: the modes are internal, so track them from the writes
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cs_q <= 8'h00;
      lk_q <= 8'h00;
    end else if (REG_REQ_I.wr) begin
      if (REG_REQ_I.addr == OFS_CNT_SYNC_DELAY) cs_q <= REG_REQ_I.wdata;
      if (REG_REQ_I.addr == OFS_LOCK_PIN_CTRL) lk_q <= REG_REQ_I.wdata;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  a_read_valid_pulse: assert property (
    REG_RVALID_O == $past(REG_REQ_I.rd)) else $error("read valid off");
  a_async_cnt_reset: assert property (
    CNT_RST_ASYNC_O == (cs_q[7:6] == 2'h1 && !SYNC_PIN_N_I))
    else $error("async reset wrong");
  a_sync_ignored: assert property (
    (cs_q[7:6] == 2'h3) [*6] |-> !CNT_RST_SYNC_O && !CNT_RST_ASYNC_O)
    else $error("sync not ignored");
  a_sync_cnt_reset: assert property (
    (cs_q[7:6] == 2'h2 && !SYNC_PIN_N_I) [*5] |=> CNT_RST_SYNC_O)
    else $error("sync reset late");
  a_lock_level: assert property (
    lk_q[5:0] == 6'h00 |=> LOCK_PIN_OE_O
    && LOCK_PIN_O == $past(DIGITAL_LOCK_FLAG_I)) else $error("level bad");
  a_lock_pchan: assert property (
    lk_q[5:0] == 6'h01 |=> LOCK_PIN_O
    && LOCK_PIN_OE_O == $past(ANALOG_LOCK_I)) else $error("pchan bad");
  a_lock_nchan: assert property (
    lk_q[5:0] == 6'h02 |=> !LOCK_PIN_O
    && LOCK_PIN_OE_O == $past(ANALOG_LOCK_I)) else $error("nchan bad");
  a_lock_current: assert property (
    lk_q[5:0] == 6'h04 |=> !LOCK_PIN_OE_O
    && LOCK_CUR_SRC_EN_O == $past(DIGITAL_LOCK_FLAG_I)) else $error("cur");
  a_lock_tristate: assert property (
    lk_q[5:0] == 6'h03 |=> !LOCK_PIN_OE_O && !LOCK_CUR_SRC_EN_O)
    else $error("tristate bad");
  a_lock_undefined: assert property (
    lk_q[5:0] > 6'h04 |=> LOCK_PIN_OE_O && !LOCK_PIN_O
    && !LOCK_CUR_SRC_EN_O) else $error("undefined code bad");
  c_read: cover property (REG_RVALID_O);
  c_sync: cover property (CNT_RST_SYNC_O);
  c_cur: cover property (LOCK_CUR_SRC_EN_O);
endmodule
bind pps_top pps_props i_chk (.*);

//--- test/pps_top_test.sv
// self-checking bench for the pll status and lock pin select block
`timescale 1ns/1ns
module pps_top_test;
  import pps_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  pps_reg_req_s req = '0;
  logic         sy_n = 1'b1;
  logic         st = 1'b0;
  logic         dl = 1'b0;
  logic         al = 1'b0;
  logic [7:0]   rdat, d, n;
  logic [2:0]   rdl, fdl;
  logic         rv, ar, sr, sp, lp, oe, cu, p;
  int           fail_count = 0;
  int           checks_done = 0;
  logic [5:0]   codes [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
                              6'h1F, 6'h20};
  always #50 clk = ~clk;
  pps_top i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req),
    .REG_RDATA_O(rdat), .REG_RVALID_O(rv), .SYNC_PIN_N_I(sy_n),
    .CNT_RST_ASYNC_O(ar), .CNT_RST_SYNC_O(sr), .REF_PATH_DELAY_O(rdl),
    .FB_PATH_DELAY_O(fdl), .STATUS_SIG_I(st), .STATUS_PIN_O(sp),
    .DIGITAL_LOCK_FLAG_I(dl), .ANALOG_LOCK_I(al), .LOCK_PIN_O(lp),
    .LOCK_PIN_OE_O(oe), .LOCK_CUR_SRC_EN_O(cu));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, v};
    @(posedge clk);
    req.wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    check({7'h00, rv}, 8'h01);
    check(rdat, e);
  endtask
  // pin is masked by the enable: its level is free while not driving
  function automatic logic [7:0] lk_exp(logic [5:0] s, logic g, logic a);
    if (s == LSEL_LEVEL_OUTPUT) return {5'h00, g, 2'h2};
    if (s == LSEL_DYN_PCHAN) return {5'h00, a, a, 1'b0};
    if (s == LSEL_DYN_NCHAN) return {6'h00, a, 1'b0};
    if (s == LSEL_HIGH_IMPEDANCE) return 8'h00;
    if (s == LSEL_CURRENT_SOURCE) return {7'h00, g};
    return 8'h02;
  endfunction
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(89154));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CNT_SYNC_DELAY, RST_CNT_SYNC_DELAY);
    rd(OFS_LOCK_PIN_CTRL, RST_LOCK_PIN_CTRL);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(OFS_CNT_SYNC_DELAY, d);
      check({2'h0, rdl, fdl}, {2'h0, d[5:0]});
      rd(OFS_CNT_SYNC_DELAY, d);
      wr(OFS_LOCK_PIN_CTRL, d);
    end
    wr(10'h01B, 8'hFF);
    rd(10'h01B, RDATA_UNMAPPED);
    rd(OFS_LOCK_PIN_CTRL, d);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_LOCK_PIN_CTRL, {2'($urandom), codes[i]});
      repeat (6) begin
        @(posedge clk);
        {dl, al} <= 2'($urandom);
        @(posedge clk);
        @(negedge clk);
        n = lk_exp(codes[i], dl, al);
        check({5'h00, lp & oe, oe, cu}, n);
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CNT_SYNC_DELAY, {m[1:0], 6'h00});
      @(posedge clk);
      sy_n <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check({6'h00, ar, sr}, {6'h00, m == 1, m == 2});
      @(posedge clk);
      sy_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
    wr(OFS_LOCK_PIN_CTRL, 8'h00);
    repeat (8) begin
      @(posedge clk);
      st <= 1'($urandom);
      @(posedge clk);
      @(negedge clk);
      check({7'h00, sp}, {7'h00, st});
    end
    @(posedge clk);
    st <= 1'b0;
    wr(OFS_LOCK_PIN_CTRL, 8'h80);
    n = 8'h00;
    p = sp;
    for (int i = 0; i < 18; i++) begin
      @(posedge clk);
      if (i < 16) st <= ~st;
      @(negedge clk);
      n = n + 8'(sp != p);
      p = sp;
    end
    check(n, 8'h04);
    end_of_test;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule
